// ---- include/pes_pkg.sv ----
// Constants, register map and bus carriers of the power-unit event status flags.
package pes_pkg;

  // ****************************************************************
  // Bus shape and register map.
  // ****************************************************************
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FLAG_W     = 8;
  localparam int unsigned SRC_W      = 7;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_MASK   = 12'h004;
  localparam logic [11:0] OFS_LEVEL  = 12'h008;

  // ****************************************************************
  // Flag positions inside the status, mask and level registers.
  // ****************************************************************
  localparam int unsigned BIT_POR    = 0;
  localparam int unsigned BIT_LCD    = 1;
  localparam int unsigned BIT_COMMS  = 2;
  localparam int unsigned BIT_SYS    = 3;
  localparam int unsigned BIT_ONKEY  = 4;
  localparam int unsigned BIT_RING   = 5;
  localparam int unsigned BIT_RTC    = 6;
  localparam int unsigned BIT_PFAIL  = 7;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0]  RST_STATUS = 8'h01;
  localparam logic [7:0]  RST_MASK   = 8'h00;
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

  // Register selected by a bus address.
  typedef enum logic [1:0] {
    PES_SEL_STATUS,
    PES_SEL_MASK,
    PES_SEL_LEVEL,
    PES_SEL_NONE
  } pes_sel_e;

  // APB request as driven by the master.
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } pes_apb_req_s;

  // APB answer of this slave.
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } pes_apb_rsp_s;

endpackage : pes_pkg

// ---- hw/pes_evt_sync.sv ----
// Pin synchroniser with agreement filter and rising-edge detector.
`timescale 1ns/1ps
module pes_evt_sync #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_r, s2_r, s3_r, flt_r, rise_r;
  logic [WIDTH-1:0] flt_nxt, rise_nxt;

  // ****************************************************************
  // Filter: a new level counts only once stages two and three agree.
  // ****************************************************************
  // The first stage is read by the second stage alone, so a metastable
  // value never reaches the filter or the edge detector.
  always_comb begin
    flt_nxt  = flt_r;
    rise_nxt = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        flt_nxt[i] = s3_r[i];
      end
      rise_nxt[i] = flt_nxt[i] & ~flt_r[i];
    end
  end

  // Registered stages; everything holds while the clock enable is low.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      flt_r  <= '0;
      rise_r <= '0;
    end else if (ce_i) begin
      s1_r   <= pin_i;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      flt_r  <= flt_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise_o  = rise_r;
  assign level_o = flt_r;

endmodule : pes_evt_sync

// ---- hw/pes_status_flags.sv ----
// Power-unit sticky event flags with APB access, mask and interrupt.
`timescale 1ns/1ps
module pes_status_flags
  import pes_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         ce_i,
  input  wire logic         warm_rst_i,
  input  wire logic         power_fail_i,
  input  wire logic         rtc_alarm_i,
  input  wire logic         modem_ring_i,
  input  wire logic         on_key_i,
  input  wire logic         sys_pll_lock_i,
  input  wire logic         comms_pll_lock_i,
  input  wire logic         lcd_pll_lock_i,
  input  wire pes_apb_req_s apb_req_i,
  output pes_apb_rsp_s      apb_rsp_o,
  output logic              irq_o
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [FLAG_W-1:0] status_r, status_nxt;
  logic [FLAG_W-1:0] mask_r, mask_nxt;
  logic [FLAG_W-1:0] clr_mask;
  logic [FLAG_W-1:0] set_mask;
  logic [SRC_W-1:0]  src_pin;
  logic [SRC_W-1:0]  src_rise;
  logic [SRC_W-1:0]  src_level;
  pes_apb_rsp_s      rsp_r, rsp_nxt;
  logic              irq_r, irq_nxt;
  logic              access;
  logic              commit;
  logic              wr_commit;
  pes_sel_e          sel;

  // Address decode, shared by the read path and the write path.
  function automatic pes_sel_e decode(input logic [ADDR_W-1:0] addr);
    pes_sel_e s;
    case (addr)
      OFS_STATUS: s = PES_SEL_STATUS;
      OFS_MASK:   s = PES_SEL_MASK;
      OFS_LEVEL:  s = PES_SEL_LEVEL;
      default:    s = PES_SEL_NONE;
    endcase
    return s;
  endfunction : decode

  // ****************************************************************
  // Event sources.
  // ****************************************************************
  // PLL inputs are lock levels; inverting them makes loss of lock
  // a rising edge like every other source.
  assign src_pin = {power_fail_i, rtc_alarm_i, modem_ring_i, on_key_i,
                    ~sys_pll_lock_i, ~comms_pll_lock_i, ~lcd_pll_lock_i};

  pes_evt_sync #(
    .WIDTH (SRC_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .pin_i     (src_pin),
    .rise_o    (src_rise),
    .level_o   (src_level)
  );

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  // Ready rises one cycle into the access phase; the write lands on
  // the edge that samples ready high, never earlier.
  assign access    = apb_req_i.psel & apb_req_i.penable;
  assign commit    = access & rsp_r.pready;
  assign wr_commit = commit & apb_req_i.pwrite;
  assign sel       = decode(apb_req_i.paddr);

  // Answer: read data, ready and error for an unmapped address.
  always_comb begin
    rsp_nxt         = '0;
    rsp_nxt.pready  = access & ~rsp_r.pready;
    rsp_nxt.pslverr = rsp_nxt.pready & (sel == PES_SEL_NONE);
    rsp_nxt.prdata  = RST_RDATA;
    if (rsp_nxt.pready && !apb_req_i.pwrite) begin
      case (sel)
        PES_SEL_STATUS: rsp_nxt.prdata[FLAG_W-1:0] = status_r;
        PES_SEL_MASK:   rsp_nxt.prdata[FLAG_W-1:0] = mask_r;
        PES_SEL_LEVEL:  rsp_nxt.prdata[FLAG_W-1:1] = src_level;
        default:        rsp_nxt.prdata = RST_RDATA;
      endcase
    end
  end

  // ****************************************************************
  // Sticky flags.
  // ****************************************************************
  // Write-one-to-clear: only ones in the written byte clear flags.
  // zero keeps flag
  assign clr_mask = (wr_commit && sel == PES_SEL_STATUS) ?
                    apb_req_i.pwdata[FLAG_W-1:0] : '0;
  // The power-on flag has no event source after reset.
  assign set_mask = {src_rise, 1'b0};

  // Next flag values; a set in the clearing cycle beats the clear.
  always_comb begin
    status_nxt = (status_r & ~clr_mask) | set_mask;
    mask_nxt   = mask_r;
    if (wr_commit && sel == PES_SEL_MASK) begin
      mask_nxt = apb_req_i.pwdata[FLAG_W-1:0];
    end
    // power-on flag survives
    // A warm reset wipes the event flags and mask but leaves bit 0,
    // so software can still tell a cold start from a warm one.
    if (warm_rst_i) begin
      status_nxt[FLAG_W-1:1] = '0;
      mask_nxt               = RST_MASK;
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // Flag, mask, answer and interrupt registers.
  // set at power-on
  // Bit 0 powers up set, since the asynchronous reset is the power-on one.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_r <= RST_STATUS;
      mask_r   <= RST_MASK;
      rsp_r    <= '0;
      irq_r    <= 1'b0;
    end else if (ce_i) begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      rsp_r    <= rsp_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign apb_rsp_o = rsp_r;
  assign irq_o     = irq_r;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  // An event on a bit, with no warm reset, leaves it set.
  property p_sets(int b);
    ce_i && set_mask[b] && !warm_rst_i |=> status_r[b];
  endproperty

  // A one written to a bit, with no event on it, clears it.
  property p_clears(int b);
    ce_i && clr_mask[b] && !set_mask[b] |=> !status_r[b];
  endproperty

  // A set bit with no clear and no warm reset stays set.
  property p_holds(int b);
    ce_i && status_r[b] && !clr_mask[b] && !warm_rst_i |=> status_r[b];
  endproperty

  // A clear bit rises only through an event.
  property p_cause(int b);
    ce_i && !status_r[b] && !set_mask[b] |=> !status_r[b];
  endproperty

  // Access phase without ready, then ready one cycle later.
  sequence s_access_wait;
    ce_i && access && !rsp_r.pready;
  endsequence

  sequence s_ready_seen;
    rsp_r.pready ##0 $past(ce_i);
  endsequence

  a_onkey_set: assert property (p_sets(BIT_ONKEY)) else $error("on-key flag not set");
  a_onkey_clear: assert property (p_clears(BIT_ONKEY)) else $error("on-key flag not cleared");
  a_sys_hold: assert property (p_holds(BIT_SYS)) else $error("system PLL flag dropped");
  a_sys_clear: assert property (p_clears(BIT_SYS)) else $error("system PLL flag not cleared");
  a_comms_set: assert property (p_sets(BIT_COMMS)) else $error("comms PLL flag not set");
  a_comms_clear: assert property (p_clears(BIT_COMMS)) else $error("comms PLL flag not cleared");
  a_lcd_cause: assert property (p_cause(BIT_LCD)) else $error("LCD PLL flag rose without event");
  a_lcd_clear: assert property (p_clears(BIT_LCD)) else $error("LCD PLL flag not cleared");
  a_por_warm_keep: assert property (
    ce_i && warm_rst_i && status_r[BIT_POR] && !clr_mask[BIT_POR] |=> status_r[BIT_POR]
  ) else $error("power-on flag lost on warm reset");
  a_por_stays_clear: assert property (
    ce_i && clr_mask[BIT_POR] |=> !status_r[BIT_POR] ##1 !status_r[BIT_POR]
  ) else $error("power-on flag returned after clear");
  a_pfail_hold: assert property (p_holds(BIT_PFAIL)) else $error("power fail flag dropped");
  a_ring_set: assert property (p_sets(BIT_RING)) else $error("ring flag not set");
  a_set_wins: assert property (
    ce_i && clr_mask[BIT_RTC] && set_mask[BIT_RTC] && !warm_rst_i |=> status_r[BIT_RTC]
  ) else $error("event lost in clearing cycle");
  // zero write keeps
  // A bit written with zero may only change through its own event.
  a_zero_keep: assert property (
    ce_i && wr_commit && sel == PES_SEL_STATUS && !warm_rst_i |=>
      (((status_r ^ $past(status_r)) & ~$past(apb_req_i.pwdata[FLAG_W-1:0]) & ~$past(set_mask)) == '0)
  ) else $error("zero write changed a flag");
  a_ready_one: assert property (s_access_wait |=> s_ready_seen)
    else $error("ready late");
  a_irq_level: assert property (ce_i |=> irq_o == |(status_r & mask_r))
    else $error("interrupt does not follow masked flags");

endmodule : pes_status_flags

// ---- verification/pes_status_flags_tb.sv ----
// Self-checking testbench for the power-unit event status flags.
`timescale 1ns/1ps
module testbench;
  import pes_pkg::*;

  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic         clk        = 1'b0;
  logic         arst_n     = 1'b0;
  logic         warm_rst   = 1'b0;
  logic [7:1]   evt_act    = 7'h00;
  pes_apb_req_s req        = '0;
  pes_apb_rsp_s rsp;
  logic         irq;
  int           err_total  = 0;
  int           checks_done = 0;
  logic [31:0]  rd_data;
  logic         rd_err;

  // Free-running clock at 250 MHz.
  always #2 clk = ~clk;

  // PLL inputs are lock levels, so an active unlock event drives them low.
  pes_status_flags uut (
    .ref_clk_i        (clk),
    .arst_n_i         (arst_n),
    .ce_i             (1'b1),
    .warm_rst_i       (warm_rst),
    .power_fail_i     (evt_act[7]),
    .rtc_alarm_i      (evt_act[6]),
    .modem_ring_i     (evt_act[5]),
    .on_key_i         (evt_act[4]),
    .sys_pll_lock_i   (~evt_act[3]),
    .comms_pll_lock_i (~evt_act[2]),
    .lcd_pll_lock_i   (~evt_act[1]),
    .apb_req_i        (req),
    .apb_rsp_o        (rsp),
    .irq_o            (irq)
  );

  // ****************************************************************
  // Bus, compare and closing tasks.
  // ****************************************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // Ready is read right after each rising edge, which shows the value that edge sampled;
  // the request is released at that same edge, by non-blocking assignment.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
    rd_data = rsp.prdata;
    rd_err  = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rd_data, exp);
  endtask : rd_chk

  // A source is held long enough to pass the synchroniser and agreement filter.
  task automatic pulse_src(input int b);
    @(posedge clk);
    evt_act[b] <= 1'b1;
    repeat (4) @(posedge clk);
    evt_act[b] <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse_src

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(OFS_STATUS, 32'h0000_0001);
    rd_chk(OFS_MASK, 32'h0000_0000);
    rd_chk(OFS_LEVEL, 32'h0000_0000);
    // Warm reset must leave the power-on flag standing.
    @(posedge clk);
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    rd_chk(OFS_STATUS, 32'h0000_0001);
    apb(1'b1, OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0001);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    // Unmapped word answers with an error and no data.
    apb(1'b1, 12'h00C, 32'h0000_00FF);
    chk_word({31'h0000_0000, rd_err}, 32'h0000_0001);
    chk_word(rd_data, 32'h0000_0000);
    // Every source sets its own flag, survives a zero write and clears on a one.
    for (int b = 1; b < 8; b++) begin
      pulse_src(b);
      rd_chk(OFS_STATUS, 32'h0000_0001 << b);
      apb(1'b1, OFS_STATUS, ~(32'h0000_0001 << b));
      rd_chk(OFS_STATUS, 32'h0000_0001 << b);
      apb(1'b1, OFS_STATUS, 32'h0000_0001 << b);
      rd_chk(OFS_STATUS, 32'h0000_0000);
    end
    // A later loss of lock sets the system flag again.
    pulse_src(3);
    rd_chk(OFS_STATUS, 32'h0000_0008);
    apb(1'b1, OFS_STATUS, 32'h0000_0008);
    // Interrupt follows the masked on-key flag and drops with its clear.
    pulse_src(4);
    chk_word({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b1, OFS_MASK, 32'h0000_0010);
    repeat (2) @(posedge clk);
    chk_word({31'h0000_0000, irq}, 32'h0000_0001);
    rd_chk(OFS_MASK, 32'h0000_0010);
    apb(1'b1, OFS_STATUS, 32'h0000_0010);
    repeat (2) @(posedge clk);
    chk_word({31'h0000_0000, irq}, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    wrap_up();
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #80000;
    err_total++;
    wrap_up();
  end

endmodule : testbench
